// File: verilog/sfs_status_regs.sv
// Behaviour
// R1: bits 15:12 low integrity, inputs 4,2,3,1
// R2: bits 11:8 high integrity, inputs 4,2,3,1
// R3: integrity results deglitched for 5 us
// R4: integrity flags stay set until read
// R5: bits 7:4 low overvoltage, clear on read
// R6: bits 3:0 high overvoltage, clear on read
// R7: offsets 0fh and 10h, reset zero
// R8: analog selftest fault sticky, diag exit during a run sets
// R9: logic selftest fault sticky until rerun passes
// R10: exciter mode fault while exciter disabled
// R11: condition present during clearing read wins
module sfs_status_regs #(
  parameter int DEGLITCH_CYCLES = sfs_pkg::SFS_DEGLITCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [3:0] lowIntegrityRaw,
  input wire logic [3:0] highIntegrityRaw,
  input wire logic [3:0] lowOvervoltRaw,
  input wire logic [3:0] highOvervoltRaw,
  input wire logic exciterMonitorHighFault,
  input wire logic exciterMonitorLowFault,
  input wire logic linkErrorFault,
  input wire logic boostOvervoltFault,
  input wire logic coreRegulatorOvercurrent,
  input wire logic exciterThermalWarning,
  input wire logic [1:0] exciterModeField,
  input wire logic analogSelftestRunning,
  input wire logic analogSelftestDone,
  input wire logic analogSelftestPass,
  input wire logic diagnosticExitCommand,
  input wire logic logicSelftestDone,
  input wire logic logicSelftestPass,
  input wire logic mainSupplyOvervolt,
  input wire logic coreSupplyOvervolt,
  input wire logic pinMismatchFault,
  input wire logic faultPinMonitor,
  input wire logic encoderAMonitor,
  input wire logic encoderBMonitor,
  input wire logic encoderIndexMonitor,
  output logic [15:0] regRdata,
  output logic regRvalid
);
  import sfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  ////////////////////////////////////////////////////////////////////////////////
  if (DEGLITCH_CYCLES < 1) begin : gBadCycles
    $error("sfs_status_regs: DEGLITCH_CYCLES must be at least 1");
  end
  // The four 4-bit fields must tile the sensor register from bit 0 upward
  if (SFS_HIGH_OVERVOLT_POS != 0 ||
      SFS_LOW_OVERVOLT_POS != SFS_HIGH_OVERVOLT_POS + 4 ||
      SFS_HIGH_INTEGRITY_POS != SFS_LOW_OVERVOLT_POS + 4 ||
      SFS_LOW_INTEGRITY_POS != SFS_HIGH_INTEGRITY_POS + 4) begin : gBadLayout
    $error("sfs_status_regs: sensor field layout does not tile 16 bits");
  end

  typedef struct packed {
    logic [15:0] sensorStatus;
    logic [15:0] supplyStatus;
    logic [15:0] rdata;
    logic rvalid;
  } sfs_regs_s;

  sfs_regs_s state_reg;
  sfs_regs_s state_next;

  logic [3:0] lowIntegrityFilt;
  logic [3:0] highIntegrityFilt;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////////////
  // Raw inputs are indexed 3:0 as inputs 4,2,3,1
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : isAddr

  // Sticky selftest fault: only a finished run may change it
  function automatic logic bistFlag(input logic held, input logic done, input logic pass);
    logic flag;
    flag = held;
    if (done) begin
      flag = !pass;
    end
    return flag;
  endfunction : bistFlag

  ////////////////////////////////////////////////////////////////////////////////
  // De-glitch filters
  ////////////////////////////////////////////////////////////////////////////////
  // R3: 5 us filter
  for (genvar i = 0; i < 4; i++) begin : gFilt
    sfs_deglitch #(.CYCLES(DEGLITCH_CYCLES)) uLow (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .rawIn(lowIntegrityRaw[i]),
      .filtOut(lowIntegrityFilt[i])
    );
    sfs_deglitch #(.CYCLES(DEGLITCH_CYCLES)) uHigh (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .rawIn(highIntegrityRaw[i]),
      .filtOut(highIntegrityFilt[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flag logic
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic rdSensor;
    logic rdSupply;
    logic [15:0] sensorSet;
    logic [15:0] supplySet;
    logic [15:0] supplyRc;
    logic aFlag;
    logic lFlag;
    rdSensor = 1'b0;
    rdSupply = 1'b0;
    sensorSet = '0;
    supplySet = '0;
    supplyRc = '0;
    aFlag = 1'b0;
    lFlag = 1'b0;
    state_next = state_reg;
    rdSensor = regRead && isAddr(regAddr, SFS_SENSOR_STATUS_OFFSET);
    rdSupply = regRead && isAddr(regAddr, SFS_SUPPLY_STATUS_OFFSET);

    // R1: low integrity field
    sensorSet[SFS_LOW_INTEGRITY_POS +: 4] = lowIntegrityFilt;
    // R2: high integrity field
    sensorSet[SFS_HIGH_INTEGRITY_POS +: 4] = highIntegrityFilt;
    // R5: low overvoltage field
    sensorSet[SFS_LOW_OVERVOLT_POS +: 4] = lowOvervoltRaw;
    // R6: high overvoltage field
    sensorSet[SFS_HIGH_OVERVOLT_POS +: 4] = highOvervoltRaw;

    // R4: clear on read
    // The read returns the value held before this clear
    if (rdSensor) begin
      state_next.sensorStatus = '0;
    end
    // R11: set beats clear
    state_next.sensorStatus = state_next.sensorStatus | sensorSet;

    // Sticky clear-on-read faults of the second register
    supplySet[SFS_EXC_MON_HIGH_POS] = exciterMonitorHighFault;
    supplySet[SFS_EXC_MON_LOW_POS] = exciterMonitorLowFault;
    supplySet[SFS_LINK_ERR_POS] = linkErrorFault;
    supplySet[SFS_BOOST_OV_POS] = boostOvervoltFault;
    supplySet[SFS_CORE_OC_POS] = coreRegulatorOvercurrent;
    supplySet[SFS_THERMAL_POS] = exciterThermalWarning;
    supplySet[SFS_MAIN_OV_POS] = mainSupplyOvervolt;
    supplySet[SFS_CORE_OV_POS] = coreSupplyOvervolt;
    supplySet[SFS_PIN_MISMATCH_POS] = pinMismatchFault;
    supplyRc = state_reg.supplyStatus & supplySet;
    if (rdSupply) begin
      supplyRc = supplySet;
    end else begin
      supplyRc = state_reg.supplyStatus | supplySet;
    end

    // R8: analog selftest sticky
    aFlag = bistFlag(state_reg.supplyStatus[SFS_ANALOG_BIST_POS], analogSelftestDone,
      analogSelftestPass);
    // Diagnostic exit during a run wins over a same-cycle pass
    if (diagnosticExitCommand && analogSelftestRunning) begin
      aFlag = 1'b1;
    end
    // R9: logic selftest sticky
    lFlag = bistFlag(state_reg.supplyStatus[SFS_LOGIC_BIST_POS], logicSelftestDone,
      logicSelftestPass);

    state_next.supplyStatus = supplyRc;
    state_next.supplyStatus[SFS_ANALOG_BIST_POS] = aFlag;
    state_next.supplyStatus[SFS_LOGIC_BIST_POS] = lFlag;
    // R10: exciter disabled flag
    state_next.supplyStatus[SFS_EXC_MODE_POS] = exciterModeField == SFS_EXC_MODE_DISABLED;
    // Pin monitors are live, one cycle behind their pins
    state_next.supplyStatus[SFS_FAULT_PIN_POS] = faultPinMonitor;
    state_next.supplyStatus[SFS_ENC_A_POS] = encoderAMonitor;
    state_next.supplyStatus[SFS_ENC_B_POS] = encoderBMonitor;
    state_next.supplyStatus[SFS_ENC_INDEX_POS] = encoderIndexMonitor;

    // R7: register decode
    // Idle cycles return zero so stale data never looks fresh
    state_next.rvalid = regRead;
    if (rdSensor) begin
      state_next.rdata = state_reg.sensorStatus;
    end else if (rdSupply) begin
      state_next.rdata = state_reg.supplyStatus;
    end else begin
      state_next.rdata = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////////
  // R7: reset to zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '{SFS_STATUS_RESET, SFS_STATUS_RESET, 16'h0000, 1'b0};
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////////
  assign regRdata = state_reg.rdata;
  assign regRvalid = state_reg.rvalid;
endmodule : sfs_status_regs

// File: verilog/sfs_pkg.sv
package sfs_pkg;
  // Register offsets
  localparam logic [7:0] SFS_SENSOR_STATUS_OFFSET = 8'h0f;
  localparam logic [7:0] SFS_SUPPLY_STATUS_OFFSET = 8'h10;
  localparam logic [15:0] SFS_STATUS_RESET = 16'h0000;
  // Field positions in sensor_input_fault_status
  localparam int SFS_LOW_INTEGRITY_POS = 12;
  localparam int SFS_HIGH_INTEGRITY_POS = 8;
  localparam int SFS_LOW_OVERVOLT_POS = 4;
  localparam int SFS_HIGH_OVERVOLT_POS = 0;
  // Field positions in supply_selftest_pin_status
  localparam int SFS_EXC_MON_HIGH_POS = 15;
  localparam int SFS_EXC_MON_LOW_POS = 14;
  localparam int SFS_LINK_ERR_POS = 13;
  localparam int SFS_BOOST_OV_POS = 12;
  localparam int SFS_CORE_OC_POS = 11;
  localparam int SFS_THERMAL_POS = 10;
  localparam int SFS_EXC_MODE_POS = 9;
  localparam int SFS_ANALOG_BIST_POS = 8;
  localparam int SFS_LOGIC_BIST_POS = 7;
  localparam int SFS_MAIN_OV_POS = 6;
  localparam int SFS_CORE_OV_POS = 5;
  localparam int SFS_PIN_MISMATCH_POS = 4;
  localparam int SFS_FAULT_PIN_POS = 3;
  localparam int SFS_ENC_A_POS = 2;
  localparam int SFS_ENC_B_POS = 1;
  localparam int SFS_ENC_INDEX_POS = 0;
  // Exciter mode code meaning disabled
  localparam logic [1:0] SFS_EXC_MODE_DISABLED = 2'h3;
  // De-glitch timing
  localparam int SFS_CLK_MHZ = 40;
  localparam int SFS_DEGLITCH_NS = 5000;
  localparam int SFS_DEGLITCH_CYCLES = (SFS_DEGLITCH_NS * SFS_CLK_MHZ + 999) / 1000;
endpackage : sfs_pkg

// File: verilog/sfs_deglitch.sv
module sfs_deglitch #(
  parameter int CYCLES = sfs_pkg::SFS_DEGLITCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic rawIn,
  output logic filtOut
);
  import sfs_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : gBadCycles
    $error("sfs_deglitch: CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] count;
    logic out;
  } sfs_glitch_s;

  sfs_glitch_s state_reg;
  sfs_glitch_s state_next;

  // Output rises only once input held high CYCLES cycles; a low input clears it at once
  always_comb begin
    state_next = state_reg;
    if (!rawIn) begin
      state_next.count = '0;
      state_next.out = 1'b0;
    end else if (state_reg.count >= CW'(CYCLES - 1)) begin
      state_next.out = 1'b1;
    end else begin
      state_next.count = state_reg.count + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign filtOut = state_reg.out;
endmodule : sfs_deglitch

// File: bench/sfs_status_regs_sva.sv
module sfs_status_regs_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [3:0] lowIntegrityRaw,
  input wire logic [3:0] highIntegrityRaw,
  input wire logic [3:0] lowOvervoltRaw,
  input wire logic [3:0] highOvervoltRaw,
  input wire logic [1:0] exciterModeField,
  input wire logic analogSelftestRunning,
  input wire logic diagnosticExitCommand,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  sequence rdSen; clkEn && regRead && regAddr == 8'h0f; endsequence
  sequence rdSup; clkEn && regRead && regAddr == 8'h10; endsequence
  sequence quiet;
    clkEn && !(|{lowIntegrityRaw, highIntegrityRaw, lowOvervoltRaw, highOvervoltRaw});
  endsequence
  ////////////////////////////////////////////////////////////////
  read_answer_a: assert property (clkEn && regRead |=> regRvalid)
    else $error("read not answered");
  idle_zero_a: assert property (clkEn && !regRead |=> !regRvalid && regRdata == 16'h0000)
    else $error("data without read");
  unmapped_zero_a: assert property (
    clkEn && regRead && regAddr != 8'h0f && regAddr != 8'h10 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  low_ovolt_a: assert property (clkEn && lowOvervoltRaw[3] ##1 rdSen |=> regRdata[7])
    else $error("low overvoltage flag lost");
  high_ovolt_a: assert property (clkEn && highOvervoltRaw[0] ##1 rdSen |=> regRdata[0])
    else $error("high overvoltage flag lost");
  exciter_off_a: assert property (
    (clkEn && exciterModeField == 2'h3) [*3] ##0 rdSup |=> regRdata[9])
    else $error("exciter mode flag missing");
  read_clears_a: assert property (
    quiet [*6] ##0 rdSen ##1 quiet ##1 rdSen |=> regRdata == 16'h0000)
    else $error("flags not cleared by read");
  diag_exit_a: assert property (
    clkEn && analogSelftestRunning && diagnosticExitCommand ##1 rdSup |=> regRdata[8])
    else $error("diagnostic exit did not flag selftest");
  set_wins_a: assert property (
    rdSen ##0 highOvervoltRaw[0] ##1 (clkEn && !regRead) ##1 rdSen |=> regRdata[0])
    else $error("flag lost to clearing read");
endmodule : sfs_status_regs_sva

bind sfs_status_regs sfs_status_regs_sva sva_u (.*);

// File: bench/sfs_host_model.sv
module sfs_host_model (
  input wire logic core_clk,
  input wire logic regRvalid,
  input wire logic [15:0] regRdata,
  output logic regRead,
  output logic [7:0] regAddr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    regRead = 1'b0;
    regAddr = 8'h00;
  end
  // One-cycle strobe, then a spare cycle so the strobe never toggles twice at once
  task automatic rd(input logic [7:0] a, output logic [15:0] data);
    regAddr = a;
    regRead = 1'b1;
    @(negedge core_clk);
    regRead = 1'b0;
    for (int k = 0; k < 4 && regRvalid !== 1'b1; k++)
      @(negedge core_clk);
    data = regRdata;
    regAddr = ~a;
    @(negedge core_clk);
  endtask : rd
endmodule : sfs_host_model

// File: bench/sfs_status_regs_tb.sv
module sfs_status_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] SEN = sfs_pkg::SFS_SENSOR_STATUS_OFFSET;
  localparam logic [7:0] SUP = sfs_pkg::SFS_SUPPLY_STATUS_OFFSET;
  logic core_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, regRead, regRvalid;
  logic [3:0] lowIntegrityRaw = 4'h0, highIntegrityRaw = 4'h0;
  logic [3:0] lowOvervoltRaw = 4'h0, highOvervoltRaw = 4'h0;
  logic [1:0] exciterModeField = 2'h0;
  logic [5:0] bist = 6'h00;
  logic [7:0] regAddr;
  logic [15:0] regRdata, d, sup = 16'h0000;
  // Selftest steps: both fail, both pass, diagnostic exit while running
  logic [5:0] bistSet [3] = '{6'h12, 6'h1b, 6'h24};
  logic [15:0] bistExp [3] = '{16'h0180, 16'h0000, 16'h0100};
  int numErrors = 0, checkCount = 0;
  always #12.5 core_clk = ~core_clk;
  sfs_status_regs #(.DEGLITCH_CYCLES(4)) dut_u (.*, .analogSelftestRunning(bist[5]),
    .analogSelftestDone(bist[4]), .analogSelftestPass(bist[3]),
    .diagnosticExitCommand(bist[2]), .logicSelftestDone(bist[1]), .logicSelftestPass(bist[0]),
    .exciterMonitorHighFault(sup[15]), .exciterMonitorLowFault(sup[14]),
    .linkErrorFault(sup[13]), .boostOvervoltFault(sup[12]),
    .coreRegulatorOvercurrent(sup[11]), .exciterThermalWarning(sup[10]),
    .mainSupplyOvervolt(sup[6]), .coreSupplyOvervolt(sup[5]), .pinMismatchFault(sup[4]),
    .faultPinMonitor(sup[3]), .encoderAMonitor(sup[2]), .encoderBMonitor(sup[1]),
    .encoderIndexMonitor(sup[0]));
  sfs_host_model host_u (.*);
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t ns: read %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    host_u.rd(a, d);
    check(d, e);
  endtask : rdc
  task automatic finishTest;
    $display("checks %0d, mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finishTest
  ////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    sys_rst = 1'b0;
    tick(6);
    rdc(SEN, 16'h0000);
    rdc(SEN, 16'h0000);
    rdc(SUP, 16'h0000);
    rdc(8'h11, 16'h0000);
    clkEn = 1'b0;
    lowOvervoltRaw = 4'hf;
    tick(2);
    lowOvervoltRaw = 4'h0;
    clkEn = 1'b1;
    rdc(SEN, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      {lowOvervoltRaw, highOvervoltRaw} = 8'h01 << i;
      tick(1);
      {lowOvervoltRaw, highOvervoltRaw} = 8'h00;
      rdc(SEN, 16'h0001 << i);
      {lowIntegrityRaw, highIntegrityRaw} = 8'h01 << i;
      tick(3);
      {lowIntegrityRaw, highIntegrityRaw} = 8'h00;
      tick(6);
      rdc(SEN, 16'h0000);
      {lowIntegrityRaw, highIntegrityRaw} = 8'h01 << i;
      tick(8);
      {lowIntegrityRaw, highIntegrityRaw} = 8'h00;
      tick(2);
      rdc(SEN, 16'h0100 << i);
      rdc(SEN, 16'h0000);
    end
    highOvervoltRaw = 4'h1;
    tick(1);
    rdc(SEN, 16'h0001);
    rdc(SEN, 16'h0001);
    highOvervoltRaw = 4'h0;
    rdc(SEN, 16'h0001);
    rdc(SEN, 16'h0000);
    $display("test sensor flags done");
    for (int i = 4; i < 16; i++) begin
      if (i < 7 || i > 9) begin
        sup[i] = 1'b1;
        tick(1);
        sup[i] = 1'b0;
        rdc(SUP, 16'h0001 << i);
        rdc(SUP, 16'h0000);
      end
    end
    sup[3:0] = 4'hf;
    tick(2);
    rdc(SUP, 16'h000f);
    sup[3:0] = 4'h0;
    tick(2);
    rdc(SUP, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      exciterModeField = 2'(m);
      tick(2);
      rdc(SUP, (m == 3) ? 16'h0200 : 16'h0000);
    end
    exciterModeField = 2'h0;
    $display("test supply flags done");
    for (int i = 0; i < 3; i++) begin
      bist = bistSet[i];
      tick(1);
      bist = 6'h00;
      rdc(SUP, bistExp[i]);
      rdc(SUP, bistExp[i]);
    end
    $display("test selftest flags done");
    finishTest();
  end
  // The whole run needs about 8.4 us
  initial begin
    #100us;
    numErrors++;
    finishTest();
  end
endmodule : sfs_status_regs_tb
